// file: rtl/pwmr_pkg.sv
package pwmr_pkg;

  // register offsets
  localparam logic [7:0] OFS_DUTY_NOW1 = 8'h30;
  localparam logic [7:0] OFS_DUTY_NOW2 = 8'h31;
  localparam logic [7:0] OFS_DUTY_NOW3 = 8'h32;
  localparam logic [7:0] OFS_CEIL1 = 8'h38;
  localparam logic [7:0] OFS_CEIL2 = 8'h39;
  localparam logic [7:0] OFS_CEIL3 = 8'h3A;
  localparam logic [7:0] OFS_CFG1 = 8'h5C;
  localparam logic [7:0] OFS_CFG2 = 8'h5D;
  localparam logic [7:0] OFS_CFG3 = 8'h5E;
  localparam logic [7:0] OFS_RAMP_ONE = 8'h62;
  localparam logic [7:0] OFS_RAMP_TWO = 8'h63;

  // reset values
  localparam logic [7:0] RST_DUTY = 8'h00;
  localparam logic [7:0] RST_CEIL = 8'hFF;
  localparam logic [7:0] RST_CFG = 8'h62;
  localparam logic [7:0] RST_RAMP = 8'h00;
  localparam logic [7:0] RD_ZERO = 8'h00;

  // field positions
  localparam int CFG_SLOW_BIT = 3;
  localparam int CFG_MODE_LSB = 5;
  localparam logic [2:0] MODE_MANUAL = 3'h7;
  localparam int RAMP1_EN_BIT = 3;
  localparam int RAMP1_CODE_LSB = 0;
  localparam int RAMP2_EN2_BIT = 7;
  localparam int RAMP2_CODE2_LSB = 4;
  localparam int RAMP2_EN3_BIT = 3;
  localparam int RAMP2_CODE3_LSB = 0;

  // duty scale: last slot index, one period is 255 slots
  localparam logic [7:0] SLOTS_MAX = 8'hFE;
  localparam logic [1:0] SLOW_LAST_PHASE = 2'h3;

  // timing: one update event per 35 s / 255 slots
  localparam int CLK_PERIOD_NS = 10;
  localparam longint UPDATE_PERIOD_NS = 137_254_902;
  localparam int UPDATE_CYCLES = int'(UPDATE_PERIOD_NS / CLK_PERIOD_NS);
  localparam int SLOT_CYCLES_DEF = 16;

  // per-channel ramp settings
  typedef struct packed {
    logic en;
    logic [2:0] code;
    logic slow;
  } pwmr_chan_cfg_t;

  // step size in slots for each code
  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code)
      3'h0: step_of = 8'h01;
      3'h1: step_of = 8'h02;
      3'h2: step_of = 8'h03;
      3'h3: step_of = 8'h05;
      3'h4: step_of = 8'h08;
      3'h5: step_of = 8'h0C;
      3'h6: step_of = 8'h18;
      default: step_of = 8'h30;
    endcase
  endfunction

  // smaller of two duty values
  function automatic logic [7:0] min8(input logic [7:0] a, input logic [7:0] b);
    min8 = (a < b) ? a : b;
  endfunction

endpackage

// file: rtl/pwmr_ramp_chan.sv
`timescale 1ns/10ps
module pwmr_ramp_chan (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // update event and settings
  input wire logic tick_i,
  input wire pwmr_pkg::pwmr_chan_cfg_t cfg_i,
  input wire logic [7:0] target_i,
  // state
  output logic [7:0] duty_o,
  output logic [1:0] phase_o
);

  logic [7:0] duty_q, duty_d;
  logic [1:0] phase_q, phase_d;

  // step and distances to target
  wire [7:0] step = pwmr_pkg::step_of(cfg_i.code);
  wire [7:0] gap_up = target_i - duty_q;
  wire [7:0] gap_dn = duty_q - target_i;
  wire move_ok = tick_i && (!cfg_i.slow || phase_q == pwmr_pkg::SLOW_LAST_PHASE);

  // next duty: bypass, step up, step down, or hold
  always_comb begin
    duty_d = duty_q;
    if (tick_i && !cfg_i.en) begin
      duty_d = target_i;
    end else if (move_ok && target_i > duty_q) begin
      duty_d = duty_q + pwmr_pkg::min8(step, gap_up);
    end else if (move_ok && target_i < duty_q) begin
      duty_d = duty_q - pwmr_pkg::min8(step, gap_dn);
    end
  end

  // divide-by-4 phase counts update events while slow and ramp enabled
  always_comb begin
    phase_d = phase_q;
    if (!cfg_i.slow || !cfg_i.en) begin
      phase_d = 2'h0;
    end else if (tick_i) begin
      phase_d = phase_q + 2'h1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      duty_q <= pwmr_pkg::RST_DUTY;
      phase_q <= 2'h0;
    end else begin
      duty_q <= duty_d;
      phase_q <= phase_d;
    end
  end

  assign duty_o = duty_q;
  assign phase_o = phase_q;

endmodule // pwmr_ramp_chan

// file: rtl/pwmr_top.sv
// Operation
// - pwm1 step code in ramp one bits 2..0
// - pwm3 step code in ramp two bits 2..0
// - pwm2 step code in ramp two bits 6..4
// - normal pace full ramp 35 s at step 1
// - config bit 3 slows channel ramp by four
// - slow pace full ramp 140 s at step 1
// - keep rising while target stays above duty
// - manual duty writes also ramp gradually
// - period is 255 slots, one slot per increment
// - compare target, add or subtract step, store
// - ramp enables at 0x62 bit 3, 0x63 bits 7/3
// - disabled channel follows target on each update
`timescale 1ns/10ps
module pwmr_top #(
  parameter int UPDATE_CYCLES = pwmr_pkg::UPDATE_CYCLES,
  parameter int SLOT_CYCLES = pwmr_pkg::SLOT_CYCLES_DEF
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // register port
  input wire logic [7:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [7:0] rdata_o,
  // computed duty from the temperature loop
  input wire logic [2:0][7:0] auto_duty_i,
  // fan drive
  output logic [2:0] pwm_o,
  output logic [2:0][7:0] duty_o,
  output logic tick_o
);

  localparam int TW = $clog2(UPDATE_CYCLES + 1);
  localparam int SW = $clog2(SLOT_CYCLES + 1);
  localparam logic [TW-1:0] TICK_LAST = TW'(UPDATE_CYCLES - 1);
  localparam logic [SW-1:0] SLOT_LAST = SW'(SLOT_CYCLES - 1);

  logic [2:0][7:0] cfg_q, ceil_q, man_q;
  logic [7:0] ramp1_q, ramp2_q, rdata_q;
  logic [TW-1:0] tick_cnt_q;
  logic tick_q;
  logic [SW-1:0] slot_div_q;
  logic [7:0] slot_q;
  logic [2:0][7:0] duty;
  logic [2:0][1:0] phase;
  logic [2:0][7:0] tgt;
  logic [2:0] manual;
  pwmr_pkg::pwmr_chan_cfg_t [2:0] ccfg;

  // write decode
  wire [2:0] wr_duty = {3{wr_i}} & {addr_i == pwmr_pkg::OFS_DUTY_NOW3,
    addr_i == pwmr_pkg::OFS_DUTY_NOW2, addr_i == pwmr_pkg::OFS_DUTY_NOW1};
  wire [2:0] wr_ceil = {3{wr_i}} & {addr_i == pwmr_pkg::OFS_CEIL3,
    addr_i == pwmr_pkg::OFS_CEIL2, addr_i == pwmr_pkg::OFS_CEIL1};
  wire [2:0] wr_cfg = {3{wr_i}} & {addr_i == pwmr_pkg::OFS_CFG3,
    addr_i == pwmr_pkg::OFS_CFG2, addr_i == pwmr_pkg::OFS_CFG1};
  wire wr_r1 = wr_i && addr_i == pwmr_pkg::OFS_RAMP_ONE;
  wire wr_r2 = wr_i && addr_i == pwmr_pkg::OFS_RAMP_TWO;

  // per-channel ramp settings from the two control registers
  assign ccfg[0].en = ramp1_q[pwmr_pkg::RAMP1_EN_BIT];
  assign ccfg[0].code = ramp1_q[pwmr_pkg::RAMP1_CODE_LSB +: 3];
  assign ccfg[1].en = ramp2_q[pwmr_pkg::RAMP2_EN2_BIT];
  assign ccfg[1].code = ramp2_q[pwmr_pkg::RAMP2_CODE2_LSB +: 3];
  assign ccfg[2].en = ramp2_q[pwmr_pkg::RAMP2_EN3_BIT];
  assign ccfg[2].code = ramp2_q[pwmr_pkg::RAMP2_CODE3_LSB +: 3];

  // target: manual value or loop value, capped by the ceiling
  for (genvar i = 0; i < 3; i++) begin : g_ch
    assign ccfg[i].slow = cfg_q[i][pwmr_pkg::CFG_SLOW_BIT];
    assign manual[i] = cfg_q[i][pwmr_pkg::CFG_MODE_LSB +: 3] == pwmr_pkg::MODE_MANUAL;
    assign tgt[i] = pwmr_pkg::min8(manual[i] ? man_q[i] : auto_duty_i[i], ceil_q[i]);

    pwmr_ramp_chan u_chan (
      .clk_i(clk_i),
      .rst_n_i(rst_n_i),
      .tick_i(tick_q),
      .cfg_i(ccfg[i]),
      .target_i(tgt[i]),
      .duty_o(duty[i]),
      .phase_o(phase[i])
    );
  end

  // register writes
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= {3{pwmr_pkg::RST_CFG}};
      ceil_q <= {3{pwmr_pkg::RST_CEIL}};
      man_q <= {3{pwmr_pkg::RST_DUTY}};
      ramp1_q <= pwmr_pkg::RST_RAMP;
      ramp2_q <= pwmr_pkg::RST_RAMP;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_duty[i]) man_q[i] <= wdata_i;
        if (wr_ceil[i]) ceil_q[i] <= wdata_i;
        if (wr_cfg[i]) cfg_q[i] <= wdata_i;
      end
      if (wr_r1) ramp1_q <= wdata_i;
      if (wr_r2) ramp2_q <= wdata_i;
    end
  end

  // read mux, unmapped reads zero
  logic [7:0] rd_mux;
  always_comb begin
    case (addr_i)
      pwmr_pkg::OFS_DUTY_NOW1: rd_mux = duty[0];
      pwmr_pkg::OFS_DUTY_NOW2: rd_mux = duty[1];
      pwmr_pkg::OFS_DUTY_NOW3: rd_mux = duty[2];
      pwmr_pkg::OFS_CEIL1: rd_mux = ceil_q[0];
      pwmr_pkg::OFS_CEIL2: rd_mux = ceil_q[1];
      pwmr_pkg::OFS_CEIL3: rd_mux = ceil_q[2];
      pwmr_pkg::OFS_CFG1: rd_mux = cfg_q[0];
      pwmr_pkg::OFS_CFG2: rd_mux = cfg_q[1];
      pwmr_pkg::OFS_CFG3: rd_mux = cfg_q[2];
      pwmr_pkg::OFS_RAMP_ONE: rd_mux = ramp1_q;
      pwmr_pkg::OFS_RAMP_TWO: rd_mux = ramp2_q;
      default: rd_mux = pwmr_pkg::RD_ZERO;
    endcase
  end

  // read data stands one cycle only
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) rdata_q <= pwmr_pkg::RD_ZERO;
    else rdata_q <= rd_i ? rd_mux : pwmr_pkg::RD_ZERO;
  end

  // update event generator, one pulse per update period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      tick_q <= tick_cnt_q == TICK_LAST;
      tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? '0 : tick_cnt_q + 1'b1;
    end
  end

  // slot counter, 255 slots per period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_div_q <= '0;
      slot_q <= 8'h00;
    end else if (slot_div_q == SLOT_LAST) begin
      slot_div_q <= '0;
      slot_q <= (slot_q == pwmr_pkg::SLOTS_MAX) ? 8'h00 : slot_q + 8'h01;
    end else begin
      slot_div_q <= slot_div_q + 1'b1;
    end
  end

  // pwm pins high for duty slots of each period
  logic [2:0] pwm_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) pwm_q <= 3'h0;
    else for (int i = 0; i < 3; i++) pwm_q[i] <= slot_q < duty[i];
  end

  assign pwm_o = pwm_q;
  assign duty_o = duty;
  assign tick_o = tick_q;
  assign rdata_o = rdata_q;

  // checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  wire [7:0] step0 = pwmr_pkg::step_of(ccfg[0].code);
  wire [7:0] step1 = pwmr_pkg::step_of(ccfg[1].code);
  wire [7:0] step2 = pwmr_pkg::step_of(ccfg[2].code);

  chk_rise_step: assert property (
    (tick_q && ccfg[0].en && !ccfg[0].slow && duty[0] < tgt[0]) |=>
      (duty[0] == $past(tgt[0]) && $past(tgt[0]) - $past(duty[0]) <= $past(step0)) ||
      (duty[0] - $past(duty[0]) == $past(step0)))
    else $error("pwm1 rise step wrong");

  chk_fall_step: assert property (
    (tick_q && ccfg[0].en && !ccfg[0].slow && duty[0] > tgt[0]) |=>
      (duty[0] == $past(tgt[0]) && $past(duty[0]) - $past(tgt[0]) <= $past(step0)) ||
      ($past(duty[0]) - duty[0] == $past(step0)))
    else $error("pwm1 fall step wrong");

  chk_pwm3_step: assert property (
    (tick_q && ccfg[2].en && !ccfg[2].slow && duty[2] < tgt[2] &&
      tgt[2] - duty[2] > step2) |=> duty[2] - $past(duty[2]) == $past(step2))
    else $error("pwm3 step wrong");

  chk_pwm2_step: assert property (
    (tick_q && ccfg[1].en && !ccfg[1].slow && duty[1] < tgt[1] &&
      tgt[1] - duty[1] > step1) |=> duty[1] - $past(duty[1]) == $past(step1))
    else $error("pwm2 step wrong");

  chk_hold_equal: assert property (
    (duty[1] == tgt[1] && ccfg[1].en) |=> duty[1] == $past(duty[1]))
    else $error("pwm2 moved at target");

  chk_bypass_follow: assert property (
    (tick_q && !ccfg[0].en) |=> duty[0] == $past(tgt[0]))
    else $error("pwm1 bypass not following");

  chk_no_tick_hold: assert property (
    !tick_q |=> $stable(duty[0]) && $stable(duty[1]) && $stable(duty[2]))
    else $error("duty moved without update");

  chk_slow_skip: assert property (
    (tick_q && ccfg[1].en && ccfg[1].slow && phase[1] != pwmr_pkg::SLOW_LAST_PHASE)
      |=> $stable(duty[1]))
    else $error("slow pwm2 stepped early");

  chk_rise_keeps: assert property (
    (tick_q && ccfg[2].en && !ccfg[2].slow && duty[2] < tgt[2]) |=> duty[2] > $past(duty[2]))
    else $error("pwm3 ramp did not rise");

  chk_manual_ramp: assert property (
    (tick_q && manual[0] && ccfg[0].en) |=>
      ((duty[0] >= $past(duty[0])) ? duty[0] - $past(duty[0]) : $past(duty[0]) - duty[0])
        <= $past(step0))
    else $error("manual duty jumped");

  chk_tick_period: assert property (
    tick_q |=> !tick_q)
    else $error("update pulse too long");

  // pwm1 and pwm2 keep climbing while the target stays above
  chk_pwm1_keeps: assert property (
    (tick_q && ccfg[0].en && !ccfg[0].slow && duty[0] < tgt[0]) |=> duty[0] > $past(duty[0]))
    else $error("pwm1 ramp did not rise");

  chk_pwm2_keeps: assert property (
    (tick_q && ccfg[1].en && !ccfg[1].slow && duty[1] < tgt[1]) |=> duty[1] > $past(duty[1]))
    else $error("pwm2 ramp did not rise");

  // pwm2 and pwm3 falling by a full step
  chk_pwm2_fall: assert property (
    (tick_q && ccfg[1].en && !ccfg[1].slow && duty[1] > tgt[1] &&
      duty[1] - tgt[1] > step1) |=> $past(duty[1]) - duty[1] == $past(step1))
    else $error("pwm2 fall step wrong");

  chk_pwm3_fall: assert property (
    (tick_q && ccfg[2].en && !ccfg[2].slow && duty[2] > tgt[2] &&
      duty[2] - tgt[2] > step2) |=> $past(duty[2]) - duty[2] == $past(step2))
    else $error("pwm3 fall step wrong");

  // pwm2 and pwm3 land on a near target without overshoot
  chk_pwm2_land: assert property (
    (tick_q && ccfg[1].en && !ccfg[1].slow && duty[1] != tgt[1] &&
      ((duty[1] < tgt[1]) ? tgt[1] - duty[1] : duty[1] - tgt[1]) <= step1)
      |=> duty[1] == $past(tgt[1]))
    else $error("pwm2 overshot target");

  chk_pwm3_land: assert property (
    (tick_q && ccfg[2].en && !ccfg[2].slow && duty[2] != tgt[2] &&
      ((duty[2] < tgt[2]) ? tgt[2] - duty[2] : duty[2] - tgt[2]) <= step2)
      |=> duty[2] == $past(tgt[2]))
    else $error("pwm3 overshot target");

  // disabled pwm2 and pwm3 follow at once
  chk_bypass_two: assert property (
    (tick_q && !ccfg[1].en) |=> duty[1] == $past(tgt[1]))
    else $error("pwm2 bypass not following");

  chk_bypass_three: assert property (
    (tick_q && !ccfg[2].en) |=> duty[2] == $past(tgt[2]))
    else $error("pwm3 bypass not following");

  // slow divide counts updates and steps on the fourth
  chk_slow_count: assert property (
    (tick_q && ccfg[1].en && ccfg[1].slow) |=> phase[1] == $past(phase[1]) + 2'h1)
    else $error("slow phase did not advance");

  chk_slow_move: assert property (
    (tick_q && ccfg[1].en && ccfg[1].slow && phase[1] == pwmr_pkg::SLOW_LAST_PHASE &&
      duty[1] < tgt[1] && tgt[1] - duty[1] > step1)
      |=> duty[1] - $past(duty[1]) == $past(step1))
    else $error("slow pwm2 missed its step");

  chk_phase_idle: assert property (
    (!ccfg[0].slow && !ccfg[2].slow) |=> phase[0] == 2'h0 && phase[2] == 2'h0)
    else $error("phase ran while not slow");

  // update pacing and slot counter
  chk_tick_align: assert property (
    tick_q |-> tick_cnt_q == '0)
    else $error("update pulse off its count");

  chk_slot_range: assert property (
    slot_q <= pwmr_pkg::SLOTS_MAX)
    else $error("slot counter past last slot");

  chk_slot_wrap: assert property (
    (slot_q == pwmr_pkg::SLOTS_MAX && slot_div_q == SLOT_LAST) |=> slot_q == 8'h00)
    else $error("slot counter did not wrap");

  // pin drive at the ends of the duty range
  chk_pin_full: assert property (
    duty[0] == 8'hFF |=> pwm_q[0])
    else $error("pwm1 pin low at full duty");

  chk_pin_idle: assert property (
    (duty[0] == 8'h00 && duty[1] == 8'h00 && duty[2] == 8'h00) |=> pwm_q == 3'h0)
    else $error("pwm pin high at zero duty");

endmodule // pwmr_top

// file: test/pwmr_fan_model.sv
`timescale 1ns/10ps
module pwmr_fan_model #(
  parameter int PERIOD = 255
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // drive pin from the limiter
  input wire logic pwm_i,
  // high slots seen over the last full period
  output logic [8:0] high_cnt_o
);
  int slot_q;
  logic [8:0] acc_q;

  // fan sees the average drive over one period
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      slot_q <= 0;
      acc_q <= 9'h000;
      high_cnt_o <= 9'h000;
    end else if (slot_q == PERIOD - 1) begin
      slot_q <= 0;
      acc_q <= 9'h000;
      high_cnt_o <= acc_q + 9'(pwm_i);
    end else begin
      slot_q <= slot_q + 1;
      acc_q <= acc_q + 9'(pwm_i);
    end
  end
endmodule // pwmr_fan_model

// file: test/pwmr_top_test.sv
`timescale 1ns/10ps
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module pwmr_top_test;
  localparam int UPD = 40;
  localparam logic [7:0] STEP [8] = '{8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0C, 8'h18, 8'h30};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [7:0] wdata_i = 8'h00;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [7:0] rdata_o;
  logic [2:0][7:0] auto_duty_i = '0;
  logic [2:0] pwm_o;
  logic [2:0][7:0] duty_o;
  logic tick_o;
  logic [8:0] fan_cnt;
  int error_cnt = 0;
  int check_count = 0;
  int n;

  pwmr_top #(.UPDATE_CYCLES(UPD), .SLOT_CYCLES(1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .auto_duty_i(auto_duty_i), .pwm_o(pwm_o), .duty_o(duty_o), .tick_o(tick_o));
  pwmr_fan_model fan (.clk_i(clk_i), .rst_n_i(rst_n_i), .pwm_i(pwm_o[0]), .high_cnt_o(fan_cnt));

  // 100 mhz clock
  initial begin
    forever #5 clk_i = ~clk_i;
  end

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e, input string nm);
    logic [7:0] v;
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(negedge clk_i);
    v = rdata_o;
    `CHK(nm, e, v)
  endtask

  // returns once the move launched by the next update event has landed
  task automatic wait_tick();
    int k;
    k = 0;
    @(negedge clk_i);
    while (tick_o !== 1'b1 && k < 4 * UPD) begin
      @(negedge clk_i);
      k++;
    end
    if (k >= 4 * UPD) error_cnt++;
    @(negedge clk_i);
  endtask

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  // watchdog for a hung test, 400 update periods
  initial begin
    #(400 * UPD * 10);
    error_cnt++;
    final_report();
  end

  initial begin
    repeat (12) @(posedge clk_i);
    rst_n_i <= 1'b1;
    rd_chk(pwmr_pkg::OFS_CEIL1, pwmr_pkg::RST_CEIL, "ceiling one");
    rd_chk(pwmr_pkg::OFS_CEIL3, pwmr_pkg::RST_CEIL, "ceiling three");
    rd_chk(pwmr_pkg::OFS_CFG2, pwmr_pkg::RST_CFG, "config two");
    rd_chk(pwmr_pkg::OFS_RAMP_TWO, pwmr_pkg::RST_RAMP, "ramp two");
    rd_chk(pwmr_pkg::OFS_DUTY_NOW1, pwmr_pkg::RST_DUTY, "duty one");
    rd_chk(8'h40, pwmr_pkg::RD_ZERO, "unmapped");
    wr(pwmr_pkg::OFS_CFG3, 8'h6A);
    rd_chk(pwmr_pkg::OFS_CFG3, 8'h6A, "config slow bit");
    wr(pwmr_pkg::OFS_CFG3, pwmr_pkg::RST_CFG);
    $display("test registers done");
    // disabled channels jump, ceiling caps the target
    wr(pwmr_pkg::OFS_CEIL1, 8'h40);
    @(posedge clk_i);
    auto_duty_i <= {8'h5A, 8'h5A, 8'h90};
    wait_tick();
    `CHK("jump one", 8'h40, duty_o[0])
    `CHK("jump two", 8'h5A, duty_o[1])
    `CHK("jump three", 8'h5A, duty_o[2])
    wr(pwmr_pkg::OFS_CEIL1, 8'hFF);
    wait_tick();
    n = 1;
    while (tick_o !== 1'b1 && n < 2 * UPD) begin
      @(negedge clk_i);
      n++;
    end
    `CHK("update spacing", UPD, n)
    $display("test direct follow done");
    // every step code on every channel, back down to zero then up one step
    for (int c = 0; c < 8; c++) begin
      @(posedge clk_i);
      auto_duty_i <= '0;
      wait_tick();
      `CHK("down to zero", 24'h00_0000, duty_o)
      wr(pwmr_pkg::OFS_RAMP_ONE, {5'h01, 3'(c)});
      wr(pwmr_pkg::OFS_RAMP_TWO, {1'b1, 3'(c), 1'b1, 3'(c)});
      @(posedge clk_i);
      auto_duty_i <= {3{8'hC8}};
      wait_tick();
      `CHK("step one", STEP[c], duty_o[0])
      `CHK("step two", STEP[c], duty_o[1])
      `CHK("step three", STEP[c], duty_o[2])
    end
    $display("test step codes done");
    // slow channel moves once per four updates
    @(posedge clk_i);
    auto_duty_i <= '0;
    wait_tick();
    wr(pwmr_pkg::OFS_CFG2, 8'h6A);
    wr(pwmr_pkg::OFS_RAMP_TWO, 8'hB8);
    @(posedge clk_i);
    auto_duty_i <= {3{8'hC8}};
    n = 0;
    while (duty_o[1] === 8'h00 && n < 6) begin
      wait_tick();
      n++;
    end
    `CHK("slow first move", 4, n)
    `CHK("slow step", 8'h05, duty_o[1])
    repeat (3) wait_tick();
    `CHK("slow hold", 8'h05, duty_o[1])
    wait_tick();
    `CHK("slow second", 8'h0A, duty_o[1])
    $display("test slow pace done");
    // manual full-scale step still ramps
    wr(pwmr_pkg::OFS_CFG2, pwmr_pkg::RST_CFG);
    @(posedge clk_i);
    auto_duty_i <= '0;
    repeat (6) wait_tick();
    wr(pwmr_pkg::OFS_CFG1, 8'hE2);
    wr(pwmr_pkg::OFS_DUTY_NOW1, 8'hFF);
    wait_tick();
    `CHK("manual 1", 8'h30, duty_o[0])
    wait_tick();
    `CHK("manual 2", 8'h60, duty_o[0])
    wr(pwmr_pkg::OFS_DUTY_NOW1, 8'hB0);
    wait_tick();
    `CHK("dip keeps rising", 8'h90, duty_o[0])
    wait_tick();
    `CHK("land on target", 8'hB0, duty_o[0])
    wait_tick();
    `CHK("hold at target", 8'hB0, duty_o[0])
    repeat (600) @(negedge clk_i);
    `CHK("fan mid slots", 9'h0B0, fan_cnt)
    wr(pwmr_pkg::OFS_DUTY_NOW1, 8'hFF);
    wait_tick();
    `CHK("manual 5", 8'hE0, duty_o[0])
    wait_tick();
    `CHK("manual full", 8'hFF, duty_o[0])
    rd_chk(pwmr_pkg::OFS_DUTY_NOW1, 8'hFF, "duty read");
    repeat (600) @(negedge clk_i);
    `CHK("fan high slots", 9'h0FF, fan_cnt)
    `CHK("idle pins", 2'h0, pwm_o[2:1])
    $display("test manual ramp done");
    final_report();
  end
endmodule // pwmr_top_test
